// ==== include/cct_pkg.sv ====
// package: register map, field positions, defaults, timing constants and types for the charger control
package cct_pkg;
   // register offsets
   localparam logic [2:0] REG_CTRL0  = 3'h0;
   localparam logic [2:0] REG_CTRL1  = 3'h1;
   localparam logic [2:0] REG_FLOAT_VOLTAGE_CODE   = 3'h2;
   localparam logic [2:0] REG_IBAT   = 3'h4;
   localparam logic [2:0] REG_SPCHG  = 3'h5;
   localparam logic [2:0] REG_SAFETY = 3'h6;
   // field positions
   localparam int KICK_BIT     = 7;
   localparam int TE_BIT       = 3;
   localparam int CE_N_BIT     = 2;
   localparam int ILIM_LSB     = 6;
   localparam int FLOAT_VOLTAGE_CODE_LSB     = 2;
   localparam int ICHG_LSB     = 4;
   localparam int DROOP_FLAG   = 4;
   localparam int CURRENT_CEILING_LSB    = 4;
   // reset values, float-voltage saturation code and voltage ceiling base
   localparam logic [7:0] CTRL1_RST  = 8'h30;
   localparam logic [5:0] FLOAT_VOLTAGE_CODE_RST   = 6'h02;
   localparam logic [2:0] ICHG_RST   = 3'h0;
   localparam logic [2:0] TERM_CURRENT_CODE_RST  = 3'h1;
   localparam logic [2:0] DROOP_RST  = 3'h4;
   localparam logic [7:0] SAFETY_RST = 8'h00;
   localparam logic [5:0] FLOAT_VOLTAGE_CODE_SAT   = 6'h2F;
   localparam logic [5:0] VOLTAGE_CEILING_BASE = 6'h23;
   // status and fault codes
   localparam logic [1:0] STAT_READY  = 2'h0;
   localparam logic [1:0] STAT_CHARGE = 2'h1;
   localparam logic [1:0] STAT_DONE   = 2'h2;
   localparam logic [1:0] STAT_FAULT  = 2'h3;
   localparam logic [2:0] FAULT_NONE  = 3'h0;
   localparam logic [2:0] FAULT_TIMER = 3'h6;
   // timing: figures in their own units, counts derived from the 100 MHz clock
   localparam longint CLK_HZ          = 100000000;
   localparam longint UNATTENDED_S    = 900;
   localparam longint WATCHDOG_S      = 32;
   localparam longint READY_MS        = 500;
   localparam longint SETTLE_MS       = 30;
   localparam longint UNATTENDED_CYC  = UNATTENDED_S * CLK_HZ;
   localparam longint WATCHDOG_CYC    = WATCHDOG_S * CLK_HZ;
   localparam longint READY_CYC       = READY_MS * CLK_HZ / 1000;
   localparam longint SETTLE_CYC      = SETTLE_MS * CLK_HZ / 1000;
   localparam int     CNT_W           = 37;
   localparam logic [6:0] STAT_PULSE_CYC = 7'h64;

   typedef enum logic [2:0] {
      CCT_IDLE   = 3'b000,
      CCT_SETTLE = 3'b001,
      CCT_CHARGE = 3'b010,
      CCT_READY  = 3'b011,
      CCT_DONE   = 3'b100,
      CCT_OFF    = 3'b101
   } cct_state_t;

   // register write request from the serial front end
   typedef struct packed {
      logic       wr;
      logic [2:0] addr;
      logic [7:0] data;
   } cct_wreq_t;

   // analog comparator levels, asynchronous at the pins, synchronised inside the core
   typedef struct packed {
      logic vbus_above_min;
      logic vbus_ovp;
      logic below_term;
      logic bat_above_weak;
      logic bat_above_short;
      logic droop_active;
      logic otg;
   } cct_sense_t;

   // decoded targets passed to the analog side
   typedef struct packed {
      logic [9:0] ichg_target_x10uv;
      logic [8:0] term_current_code_target_x100uv;
      logic [10:0] vfloat_mv_m3000;
      logic [1:0] input_limit_code;
      logic [9:0] droop_mv_m4000;
   } cct_targets_t;

   // sense-voltage lookup, 0.1 mV units, shared by charge current and its ceiling
   function automatic logic [9:0] ichg_x100uv(input logic [2:0] code);
      logic [9:0] v;
      v = 10'h000;
      unique case (code)
         3'h0: v = 10'h176;
         3'h1: v = 10'h1BA;
         3'h2: v = 10'h1FE;
         3'h3: v = 10'h242;
         3'h4: v = 10'h2CA;
         3'h5: v = 10'h30E;
         3'h6: v = 10'h396;
         3'h7: v = 10'h3DA;
      endcase
      return v;
   endfunction
endpackage

// ==== test/cct_core_checker.sv ====
// assertion checker for the charger control core
`timescale 1ns/1ps
module cct_core_checker #(
   parameter longint SETTLE_CYC = 30
) (
   // clock and reset
   input wire logic                  clock,
   input wire logic                  rst_n,
   // register side and comparator pins
   input wire cct_pkg::cct_wreq_t    wreq,
   input wire logic [2:0]            rd_addr,
   input wire logic [7:0]            rd_data,
   input wire cct_pkg::cct_sense_t   sense_pin,
   // charger side
   input wire logic                  pwm_enable,
   input wire logic                  vbus_load,
   input wire logic                  stat_pulse,
   input wire cct_pkg::cct_targets_t targets
);
   logic [31:0] load_run;
   logic [31:0] next_load_run;
   logic [7:0]  stat_run;
   logic [7:0]  next_stat_run;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // saturating counts so a long level never wraps
   always_comb begin
      next_load_run = vbus_load ? load_run + {31'h0, ~&load_run} : 32'h0;
      next_stat_run = stat_pulse ? stat_run + {7'h0, ~&stat_run} : 8'h0;
   end
   always_ff @(posedge clock) begin
      load_run <= rst_n ? next_load_run : 32'h0;
      stat_run <= rst_n ? next_stat_run : 8'h0;
   end
   a_ichg_table:
      assert property ($past(rst_n, 3) |-> targets.ichg_target_x10uv inside {10'h176, 10'h1BA,
         10'h1FE, 10'h242, 10'h2CA, 10'h30E, 10'h396, 10'h3DA}) else $error("ichg off table");
   a_term_current_code_step:
      assert property ($past(rst_n, 3) |-> targets.term_current_code_target_x100uv % 9'h022 == 9'h000
         && targets.term_current_code_target_x100uv inside {[9'h022:9'h110]}) else $error("term_current_code step");
   a_droop_step:
      assert property ($past(rst_n, 3) |-> (targets.droop_mv_m4000 + 10'h01B) % 10'h050 == 0
         && targets.droop_mv_m4000 inside {[10'h0D5:10'h305]}) else $error("droop step");
   a_load_no_pwm:
      assert property (vbus_load |-> !pwm_enable) else $error("load while charging");
   a_load_needs_supply:
      assert property (!sense_pin.vbus_above_min [*5] |-> !vbus_load) else $error("load idle");
   a_pwm_needs_supply:
      assert property (!sense_pin.vbus_above_min [*6] |-> !pwm_enable) else $error("no supply");
   a_settle_first:
      assert property ($rose(pwm_enable) |-> load_run >= SETTLE_CYC - 2)
         else $error("charge before validation");
   a_pulse_length:
      assert property ($fell(stat_pulse) |-> stat_run == 8'h64) else $error("pulse length");
   c_start: cover property ($rose(pwm_enable));
   c_pulse: cover property ($rose(stat_pulse));
   c_term: cover property (sense_pin.below_term && $fell(pwm_enable));
endmodule
bind cct_core cct_core_checker #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.clock(clock), .rst_n(rst_n),
   .wreq(wreq), .rd_addr(rd_addr), .rd_data(rd_data), .sense_pin(sense_pin),
   .pwm_enable(pwm_enable), .vbus_load(vbus_load), .stat_pulse(stat_pulse), .targets(targets));

// ==== test/cct_host_model.sv ====
// host model: passes bench writes on and kicks the watchdog
`timescale 1ns/1ps
module cct_host_model #(
   parameter int KICK_GAP = 200
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_n,
   // bench requests
   input  wire cct_pkg::cct_wreq_t cmd,
   input  wire logic               kick_en,
   // device write port
   output cct_pkg::cct_wreq_t      wreq
);
   cct_pkg::cct_wreq_t next_wreq;
   int                 gap;
   int                 next_gap;
   always_comb begin
      next_gap = gap + 1;
      next_wreq = wreq;
      next_wreq.wr = 1'b0;
      // idle data keeps moving so a stale byte never passes for a write
      next_wreq.data = ~wreq.data;
      if (cmd.wr) begin
         next_wreq = cmd;
      end else if (kick_en && gap >= KICK_GAP) begin
         next_wreq = {1'b1, cct_pkg::REG_CTRL0, 8'h80};
         next_gap = 0;
      end
   end
   always_ff @(posedge clock) begin
      wreq <= rst_n ? next_wreq : '0;
      gap <= rst_n ? next_gap : 0;
   end
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the charger control core
`timescale 1ns/1ps
module tb_top;
   localparam longint UN_CYC = 2000;
   localparam longint WD_CYC = 500;
   localparam longint RY_CYC = 50;
   localparam longint ST_CYC = 30;
   logic                  clock;
   logic                  rst_n;
   logic                  kick_en;
   logic [2:0]            rd_addr;
   logic [7:0]            rd_data;
   logic                  pwm_enable;
   logic                  vbus_load;
   logic                  stat_pulse;
   logic [15:0]           lfsr;
   cct_pkg::cct_wreq_t    cmd;
   cct_pkg::cct_wreq_t    wreq;
   cct_pkg::cct_sense_t   sense;
   cct_pkg::cct_targets_t targets;
   int                    error_cnt = 0;
   int                    checked = 0;
   int                    cyc = 0;
   int                    vceil = 36;
   int                    iceil = 2;
   int                    ichg_tab[$] = '{374, 442, 510, 578, 714, 782, 918, 986};
   cct_core #(.UNATTENDED_CYC(UN_CYC), .WATCHDOG_CYC(WD_CYC), .READY_CYC(RY_CYC),
      .SETTLE_CYC(ST_CYC)) uut (.clock(clock), .rst_n(rst_n), .wreq(wreq), .rd_addr(rd_addr),
      .rd_data(rd_data), .sense_pin(sense), .pwm_enable(pwm_enable), .vbus_load(vbus_load),
      .stat_pulse(stat_pulse), .targets(targets));
   cct_host_model #(.KICK_GAP(200)) host (.clock(clock), .rst_n(rst_n), .cmd(cmd),
      .kick_en(kick_en), .wreq(wreq));
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      cmd <= {1'b1, a, d};
      @(posedge clock);
      cmd.wr <= 1'b0;
      repeat (4) @(posedge clock);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock);
      rd_addr <= a;
      repeat (3) @(posedge clock);
      #1 chk({24'h0, rd_data & m}, {24'h0, e});
   endtask
   task automatic wait_on(ref logic s, input logic lvl, input int max);
      int n;
      n = 0;
      while (s !== lvl && n < max) begin
         @(posedge clock);
         #1 n++;
      end
      chk({31'h0, s}, {31'h0, lvl});
   endtask
   task automatic tally_and_finish;
      $display("TB: checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 15000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      rst_n = 1'b0;
      cmd = '0;
      kick_en = 1'b0;
      rd_addr = 3'h0;
      sense = '0;
      lfsr = 16'h87BC;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (10) @(posedge clock);
      #1 chk({30'h0, pwm_enable, vbus_load}, 32'h0);
      sense.vbus_above_min <= 1'b1;
      wait_on(vbus_load, 1'b1, 10);
      repeat (ST_CYC - 6) @(posedge clock);
      #1 chk({31'h0, pwm_enable}, 32'h0);
      wait_on(pwm_enable, 1'b1, 20);
      chk({21'h0, targets.vfloat_mv_m3000}, 540);
      chk({22'h0, targets.ichg_target_x10uv}, ichg_tab[0]);
      chk({30'h0, targets.input_limit_code}, 32'h0);
      @(posedge clock);
      sense.otg <= 1'b1;
      sense.bat_above_short <= 1'b1;
      repeat (6) @(posedge clock);
      #1 chk({30'h0, targets.input_limit_code}, 32'h1);
      rdc(cct_pkg::REG_SAFETY, 8'hFF, cct_pkg::SAFETY_RST);
      rdc(cct_pkg::REG_FLOAT_VOLTAGE_CODE, 8'hFC, {cct_pkg::FLOAT_VOLTAGE_CODE_RST, 2'h0});
      rdc(cct_pkg::REG_CTRL1, 8'hFF, cct_pkg::CTRL1_RST);
      wr(cct_pkg::REG_SAFETY, 8'h21);
      kick_en <= 1'b1;
      rdc(cct_pkg::REG_SAFETY, 8'hFF, 8'h21);
      for (int c = 0; c < 8; c++) begin
         lfsr = lfsr_next(lfsr);
         wr(cct_pkg::REG_FLOAT_VOLTAGE_CODE, {lfsr[7:2], 2'h0});
         rdc(cct_pkg::REG_FLOAT_VOLTAGE_CODE, 8'hFC, 8'(lfsr[7:2] > vceil ? vceil * 4 : lfsr[7:2] * 4));
         chk({21'h0, targets.vfloat_mv_m3000},
            {21'h0, 11'(500 + 20 * (lfsr[7:2] > vceil ? vceil : lfsr[7:2]))});
         wr(cct_pkg::REG_IBAT, {1'b0, 3'(c), 1'b0, 3'(c)});
         chk({22'h0, targets.ichg_target_x10uv}, ichg_tab[c > iceil ? iceil : c]);
         chk({23'h0, targets.term_current_code_target_x100uv}, 34 * (c + 1));
         wr(cct_pkg::REG_SPCHG, {5'h0, 3'(c)});
         chk({22'h0, targets.droop_mv_m4000}, 213 + 80 * c);
         wr(cct_pkg::REG_CTRL1, {2'(c), 6'h38});
         chk({30'h0, targets.input_limit_code}, c % 4);
      end
      wr(cct_pkg::REG_SAFETY, 8'h7F);
      rdc(cct_pkg::REG_SAFETY, 8'hFF, 8'h21);
      sense.droop_active <= 1'b1;
      rdc(cct_pkg::REG_SPCHG, 8'h10, 8'h10);
      sense.droop_active <= 1'b0;
      rdc(cct_pkg::REG_SPCHG, 8'h10, 8'h00);
      // termination ignored while disabled, then taken once enabled
      wr(cct_pkg::REG_CTRL1, 8'h30);
      sense.below_term <= 1'b1;
      repeat (20) @(posedge clock);
      #1 chk({31'h0, pwm_enable}, 32'h1);
      wr(cct_pkg::REG_CTRL1, 8'h38);
      wait_on(pwm_enable, 1'b0, 20);
      rdc(cct_pkg::REG_CTRL0, 8'h30, {2'h0, cct_pkg::STAT_READY, 4'h0});
      repeat (RY_CYC) @(posedge clock);
      rdc(cct_pkg::REG_CTRL0, 8'h30, {2'h0, cct_pkg::STAT_DONE, 4'h0});
      sense.below_term <= 1'b0;
      kick_en <= 1'b0;
      // the watchdog only runs while charging, so restart from done first
      wr(cct_pkg::REG_CTRL1, 8'h38);
      wait_on(pwm_enable, 1'b1, ST_CYC + 20);
      wait_on(stat_pulse, 1'b1, WD_CYC + 50);
      rdc(cct_pkg::REG_CTRL0, 8'h07, cct_pkg::FAULT_TIMER);
      rdc(cct_pkg::REG_FLOAT_VOLTAGE_CODE, 8'hFC, {cct_pkg::FLOAT_VOLTAGE_CODE_RST, 2'h0});
      wait_on(pwm_enable, 1'b1, ST_CYC + 150);
      chk({30'h0, targets.input_limit_code}, 32'h1);
      repeat (UN_CYC - 300) @(posedge clock);
      #1 chk({31'h0, pwm_enable}, 32'h1);
      wait_on(pwm_enable, 1'b0, 400);
      rdc(cct_pkg::REG_CTRL0, 8'h07, cct_pkg::FAULT_TIMER);
      rdc(cct_pkg::REG_CTRL1, 8'h04, 8'h04);
      tally_and_finish();
   end
endmodule

// ==== verilog/cct_core.sv ====
// charger control: registers, safety clamps, charge sequencing and safety timers
`timescale 1ns/1ps
module cct_core #(
   parameter logic AUTO_START  = 1'b1,
   parameter logic SPECIAL_CHG = 1'b1,
   parameter logic TERM_STEP33 = 1'b0,
   parameter longint UNATTENDED_CYC = cct_pkg::UNATTENDED_CYC,
   parameter longint WATCHDOG_CYC   = cct_pkg::WATCHDOG_CYC,
   parameter longint READY_CYC      = cct_pkg::READY_CYC,
   parameter longint SETTLE_CYC     = cct_pkg::SETTLE_CYC
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 rst_n,
   // register access from the serial front end
   input  wire cct_pkg::cct_wreq_t   wreq,
   input  wire logic [2:0]           rd_addr,
   output logic [7:0]                rd_data,
   // analog comparators, asynchronous
   input  wire cct_pkg::cct_sense_t  sense_pin,
   // charger controls
   output logic                      pwm_enable,
   output logic                      vbus_load,
   output logic                      stat_pulse,
   output cct_pkg::cct_targets_t     targets
);
   // comparator levels are asynchronous, so nothing reads them before the second flop
   cct_pkg::cct_sense_t s;
   cct_sync #(.W(7)) u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .din   (sense_pin),
      .dout  (s)
   );

   // register state
   logic [7:0] ctrl0, ctrl1, float_voltage_code, ibat, spchg, safety;
   logic [7:0] next_ctrl0, next_ctrl1, next_float_voltage_code, next_ibat, next_spchg, next_safety;
   logic       safety_open, next_safety_open;
   logic       short_q, next_short_q;
   logic       host_mode, next_host_mode;
   logic       wd_expired, un_expired, rdy_expired, set_expired;
   cct_pkg::cct_state_t state, next_state;
   logic [6:0] pulse_cnt, next_pulse_cnt;
   logic [7:0] next_rd_data;
   cct_pkg::cct_targets_t next_targets;
   logic       next_pwm, next_load, next_stat;
   logic       any_wr, vbus_ok, charging;
   logic [5:0] w_float_voltage_code, v_ceil;
   logic [2:0] w_ichg;
   logic       wd_restart, boot_defaults;
   logic [8:0] term_current_code_step;
   logic [5:0] float_voltage_code_code;
   logic [7:0] ctrl0_view;

   function automatic logic [7:0] reg_read(input logic [2:0] a, input logic [7:0] r0,
      input logic [7:0] r1, input logic [7:0] r2, input logic [7:0] r4,
      input logic [7:0] r5, input logic [7:0] r6);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         cct_pkg::REG_CTRL0:  v = r0;
         cct_pkg::REG_CTRL1:  v = r1;
         cct_pkg::REG_FLOAT_VOLTAGE_CODE:   v = r2;
         cct_pkg::REG_IBAT:   v = r4;
         cct_pkg::REG_SPCHG:  v = r5;
         cct_pkg::REG_SAFETY: v = r6;
         default:             v = 8'h00;
      endcase
      return v;
   endfunction

   // a write strobe aimed at one register offset
   function automatic logic wr_hit(input cct_pkg::cct_wreq_t w, input logic [2:0] a);
      return w.wr && (w.addr == a);
   endfunction

   assign any_wr  = wreq.wr;
   assign vbus_ok = s.vbus_above_min && !s.vbus_ovp;
   assign charging = (state == cct_pkg::CCT_CHARGE);
   // in host mode a status write without the kick bit leaves the watchdog running down
   assign wd_restart = any_wr && !(wr_hit(wreq, cct_pkg::REG_CTRL0)
                                   && !wreq.data[cct_pkg::KICK_BIT] && host_mode);
   // weak battery at the end of validation outside host mode: defaults, and charging starts regardless of ctrl1
   assign boot_defaults = (state == cct_pkg::CCT_SETTLE) && set_expired && AUTO_START
                          && !s.bat_above_weak && !host_mode;

   // while charging, the watchdog runs in host mode, the unattended timer otherwise
   cct_timer u_wd (
      .clock   (clock),
      .rst_n   (rst_n),
      .run     (charging && host_mode),
      .restart (wd_restart),
      .limit   (cct_pkg::CNT_W'(WATCHDOG_CYC)),
      .expired (wd_expired)
   );
   cct_timer u_un (
      .clock   (clock),
      .rst_n   (rst_n),
      .run     (charging && !host_mode),
      .restart (any_wr),
      .limit   (cct_pkg::CNT_W'(UNATTENDED_CYC)),
      .expired (un_expired)
   );
   cct_timer u_rdy (
      .clock   (clock),
      .rst_n   (rst_n),
      .run     (state == cct_pkg::CCT_READY),
      .restart (1'b0),
      .limit   (cct_pkg::CNT_W'(READY_CYC)),
      .expired (rdy_expired)
   );
   // a dip or overvoltage clears the count, so validation always runs in full
   cct_timer u_set (
      .clock   (clock),
      .rst_n   (rst_n),
      .run     (state == cct_pkg::CCT_SETTLE && vbus_ok),
      .restart (1'b0),
      .limit   (cct_pkg::CNT_W'(SETTLE_CYC)),
      .expired (set_expired)
   );

   // clamp incoming values against the safety ceilings
   always_comb begin
      v_ceil = cct_pkg::VOLTAGE_CEILING_BASE + {2'b00, safety[3:0]};
      w_float_voltage_code = wreq.data[7:cct_pkg::FLOAT_VOLTAGE_CODE_LSB];
      if (w_float_voltage_code > v_ceil) begin
         w_float_voltage_code = v_ceil;
      end
      w_ichg = wreq.data[6:cct_pkg::ICHG_LSB];
      if (cct_pkg::ichg_x100uv(w_ichg) >
          cct_pkg::ichg_x100uv(safety[6:cct_pkg::CURRENT_CEILING_LSB])) begin
         w_ichg = safety[6:cct_pkg::CURRENT_CEILING_LSB];
      end
   end

   // register file and safety lock
   always_comb begin
      next_ctrl0       = ctrl0;
      next_ctrl1       = ctrl1;
      next_float_voltage_code        = float_voltage_code;
      next_ibat        = ibat;
      next_spchg       = spchg;
      next_safety      = safety;
      next_safety_open = safety_open;
      next_short_q     = s.bat_above_short;
      next_host_mode   = host_mode;
      next_ctrl0[cct_pkg::KICK_BIT] = 1'b0;
      if (any_wr) begin
         next_host_mode = 1'b1;
         unique case (wreq.addr)
            cct_pkg::REG_CTRL0:  next_ctrl0[6:3] = wreq.data[6:3];
            cct_pkg::REG_CTRL1:  next_ctrl1 = wreq.data;
            cct_pkg::REG_FLOAT_VOLTAGE_CODE:   next_float_voltage_code = {w_float_voltage_code, wreq.data[1:0]};
            cct_pkg::REG_IBAT:   next_ibat = {1'b0, w_ichg, 1'b0, wreq.data[2:0]};
            cct_pkg::REG_SPCHG:  next_spchg[2:0] = wreq.data[2:0];
            cct_pkg::REG_SAFETY: begin
               if (safety_open) begin
                  next_safety = {1'b0, wreq.data[6:0]};
               end
            end
            default: ;
         endcase
         // a safety write itself never closes the window
         if (wreq.addr != cct_pkg::REG_SAFETY) begin
            next_safety_open = 1'b0;
         end
      end
      if (s.bat_above_short && !short_q) begin
         next_safety      = cct_pkg::SAFETY_RST;
         next_safety_open = 1'b1;
      end else if (!s.bat_above_short) begin
         next_safety_open = 1'b0;
      end
      // droop flag is hardware status; it overrides any write in the same cycle
      next_spchg[cct_pkg::DROOP_FLAG] = SPECIAL_CHG && s.droop_active && charging;
      // defaults on watchdog expiry, or on a weak-battery power-on
      if (wd_expired || boot_defaults) begin
         next_ctrl1     = cct_pkg::CTRL1_RST;
         next_float_voltage_code      = {cct_pkg::FLOAT_VOLTAGE_CODE_RST, 2'b00};
         next_ibat      = {1'b0, cct_pkg::ICHG_RST, 1'b0, cct_pkg::TERM_CURRENT_CODE_RST};
         next_spchg[2:0] = cct_pkg::DROOP_RST;
         next_host_mode = 1'b0;
      end
      if (wd_expired || un_expired) begin
         next_ctrl0[2:0] = cct_pkg::FAULT_TIMER;
      end
      if (un_expired) begin
         next_ctrl1[cct_pkg::CE_N_BIT] = 1'b1;
      end
   end

   // charge sequencing
   always_comb begin
      next_state     = state;
      next_pulse_cnt = (pulse_cnt != 7'h00) ? pulse_cnt - 7'h01 : 7'h00;
      unique case (state)
         cct_pkg::CCT_IDLE: begin
            if (s.vbus_above_min) begin
               next_state = cct_pkg::CCT_SETTLE;
            end
         end
         cct_pkg::CCT_SETTLE: begin
            if (!s.vbus_above_min) begin
               next_state = cct_pkg::CCT_IDLE;
            end else if (boot_defaults) begin
               next_state = cct_pkg::CCT_CHARGE;
            end else if (set_expired && !ctrl1[cct_pkg::CE_N_BIT]
                         && (AUTO_START || host_mode)) begin
               next_state = cct_pkg::CCT_CHARGE;
            end
         end
         cct_pkg::CCT_CHARGE: begin
            if (!vbus_ok) begin
               next_state = cct_pkg::CCT_IDLE;
            end else if (un_expired) begin
               next_state = cct_pkg::CCT_OFF;
            end else if (wd_expired) begin
               next_state = cct_pkg::CCT_SETTLE;
            end else if (s.below_term && ctrl1[cct_pkg::TE_BIT]) begin
               next_state = cct_pkg::CCT_READY;
            end
         end
         cct_pkg::CCT_READY: begin
            if (rdy_expired) begin
               next_state = vbus_ok ? cct_pkg::CCT_DONE : cct_pkg::CCT_IDLE;
            end
         end
         cct_pkg::CCT_DONE, cct_pkg::CCT_OFF: begin
            if (!s.vbus_above_min) begin
               next_state = cct_pkg::CCT_IDLE;
            end else if (wr_hit(wreq, cct_pkg::REG_CTRL1)
                         && !wreq.data[cct_pkg::CE_N_BIT]) begin
               // the disable bit comes from the write itself, so one write restarts after off
               next_state = cct_pkg::CCT_SETTLE;
            end
         end
         default: next_state = cct_pkg::CCT_IDLE;
      endcase
      // a second expiry while the pulse still stands restarts its full length
      if (wd_expired) begin
         next_pulse_cnt = cct_pkg::STAT_PULSE_CYC;
      end
   end

   // outputs and decoded targets
   always_comb begin
      next_pwm  = (state == cct_pkg::CCT_CHARGE);
      next_load = (state == cct_pkg::CCT_SETTLE);
      next_stat = (pulse_cnt != 7'h00);
      // status bits are read from the sequencer, not stored
      ctrl0_view   = {ctrl0[7:6], state_code(state), ctrl0[3:0]};
      next_rd_data = reg_read(rd_addr, ctrl0_view, ctrl1, float_voltage_code, ibat, spchg, safety);
      next_targets.ichg_target_x10uv = cct_pkg::ichg_x100uv(ibat[6:cct_pkg::ICHG_LSB]);
      // code 0 is already one step, so the threshold is code plus one steps
      term_current_code_step = TERM_STEP33 ? 9'h021 : 9'h022;
      next_targets.term_current_code_target_x100uv =
         9'(({6'h00, ibat[2:0]} + 9'h001) * term_current_code_step);
      // codes past the top of the range all give the top float voltage
      float_voltage_code_code = (float_voltage_code[7:2] >= cct_pkg::FLOAT_VOLTAGE_CODE_SAT) ? cct_pkg::FLOAT_VOLTAGE_CODE_SAT : float_voltage_code[7:2];
      next_targets.vfloat_mv_m3000 = 11'(500 + 20 * float_voltage_code_code);
      // the pin steers the limit only while the unattended timer is the one running
      next_targets.input_limit_code = (AUTO_START && !host_mode && charging)
         ? (s.otg ? 2'b01 : 2'b00) : ctrl1[7:cct_pkg::ILIM_LSB];
      next_targets.droop_mv_m4000 = 10'(213 + 80 * spchg[2:0]);
   end

   function automatic logic [1:0] state_code(input cct_pkg::cct_state_t st);
      logic [1:0] c;
      c = cct_pkg::STAT_READY;
      unique case (st)
         cct_pkg::CCT_CHARGE, cct_pkg::CCT_SETTLE: c = cct_pkg::STAT_CHARGE;
         cct_pkg::CCT_DONE:                        c = cct_pkg::STAT_DONE;
         cct_pkg::CCT_OFF:                         c = cct_pkg::STAT_FAULT;
         default:                                  c = cct_pkg::STAT_READY;
      endcase
      return c;
   endfunction

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl0       <= 8'h00;
         ctrl1       <= cct_pkg::CTRL1_RST;
         float_voltage_code        <= {cct_pkg::FLOAT_VOLTAGE_CODE_RST, 2'b00};
         ibat        <= {1'b0, cct_pkg::ICHG_RST, 1'b0, cct_pkg::TERM_CURRENT_CODE_RST};
         spchg       <= {5'h00, cct_pkg::DROOP_RST};
         safety      <= cct_pkg::SAFETY_RST;
         safety_open <= 1'b0;
         short_q     <= 1'b0;
         host_mode   <= 1'b0;
         state       <= cct_pkg::CCT_IDLE;
         pulse_cnt   <= 7'h00;
         rd_data     <= 8'h00;
         pwm_enable  <= 1'b0;
         vbus_load   <= 1'b0;
         stat_pulse  <= 1'b0;
         targets     <= '0;
      end else begin
         ctrl0       <= next_ctrl0;
         ctrl1       <= next_ctrl1;
         float_voltage_code        <= next_float_voltage_code;
         ibat        <= next_ibat;
         spchg       <= next_spchg;
         safety      <= next_safety;
         safety_open <= next_safety_open;
         short_q     <= next_short_q;
         host_mode   <= next_host_mode;
         state       <= next_state;
         pulse_cnt   <= next_pulse_cnt;
         rd_data     <= next_rd_data;
         pwm_enable  <= next_pwm;
         vbus_load   <= next_load;
         stat_pulse  <= next_stat;
         targets     <= next_targets;
      end
   end
endmodule

// ==== verilog/cct_sync.sv ====
// two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
module cct_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clock,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_dout;

   always_comb begin
      next_meta = din;
      next_dout = meta;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta <= '0;
         dout <= '0;
      end else begin
         meta <= next_meta;
         dout <= next_dout;
      end
   end
endmodule

// ==== verilog/cct_timer.sv ====
// restartable interval counter with a one-cycle expiry pulse
`timescale 1ns/1ps
module cct_timer (
   // clock and reset
   input  wire logic                    clock,
   input  wire logic                    rst_n,
   // control
   input  wire logic                    run,
   input  wire logic                    restart,
   input  wire logic [cct_pkg::CNT_W-1:0] limit,
   // status
   output logic                         expired
);
   logic [cct_pkg::CNT_W-1:0] count;
   logic [cct_pkg::CNT_W-1:0] next_count;
   logic                      next_expired;

   always_comb begin
      next_count   = count;
      next_expired = 1'b0;
      if (restart || !run) begin
         next_count = '0;
      end else if (count >= limit - 1'b1) begin
         next_count   = '0;
         next_expired = 1'b1;
      end else begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count   <= '0;
         expired <= 1'b0;
      end else begin
         count   <= next_count;
         expired <= next_expired;
      end
   end
endmodule
